/* inc/fesr_pkg.sv */
// Constants, opcodes and timing shared by the flash erase device and host.
// Assumes one system clock of 250 MHz on both ends.
package fesr_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESUME_BUSY_NS = 200;
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
  localparam int ERASE_GAP_MS = 12;
  localparam int PROG_GAP_MS = 3;
  localparam int ERASE_GAP_CYC = ERASE_GAP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_GAP_CYC = PROG_GAP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 32;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
  localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_DUAL_PROGRAM = 8'ha2;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  // ----------------------------------------------------------------
  // Frame layout and status bits
  // ----------------------------------------------------------------
  localparam int OP_BITS = 8;
  localparam int ERASE_BITS = 32;
  localparam int STATUS_BITS = 8;
  localparam int BLOCK_LSB = 16;
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int SUS_BIT2 = 7;
  localparam int SUS_BIT = 15;
  localparam int BP_W = 5;
  localparam logic [4:0] BP_NONE = 5'h00;
  // Host command codes
  localparam logic [2:0] HC_ERASE64 = 3'h0;
  localparam logic [2:0] HC_CHIP = 3'h1;
  localparam logic [2:0] HC_SUSPEND = 3'h2;
  localparam logic [2:0] HC_RESUME = 3'h3;
  localparam logic [2:0] HC_WREN = 3'h4;
  localparam logic [2:0] HC_STAT1 = 3'h5;
  localparam logic [2:0] HC_STAT2 = 3'h6;
  localparam logic [2:0] HC_CHIP_B = 3'h7;
endpackage : fesr_pkg

/* inc/fesr_link_if.sv */
// Serial link between flash controller and flash device.
// Assumes the bench supplies sys_clk to both ends separately.
`timescale 1ns/1ns
interface fesr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  modport device (input cs_n, input sck, input mosi, output miso);
  modport host (output cs_n, output sck, output mosi, input miso);
endinterface : fesr_link_if

/* logic/fesr_device.sv */
// Flash device command engine: erase 64 kB, chip erase, suspend, resume.
// Assumes link pins are asynchronous and sampled on sys_clk.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module fesr_device #(
  parameter int BLOCK_ERASE_CYC = 8000,
  parameter int CHIP_ERASE_CYC = 16000,
  parameter int SUSPEND_LAT_CYC = 100,
  parameter int ADDR_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  fesr_link_if.device link,
  input wire logic [fesr_pkg::BP_W-1:0] block_protect,
  input wire logic power_lost,
  output logic erase_block_ff,
  output logic [7:0] erase_block_num_ff,
  output logic erase_chip_ff,
  output logic busy_flag_ff,
  output logic write_enable_latch_ff,
  output logic suspend_status_flag_ff
);
  localparam int CNT_W = fesr_pkg::CNT_W;
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] cs_sync_ff, sck_sync_ff, mosi_sync_ff;
  logic cs_d_ff, sck_d_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_ff <= 2'h3;
      sck_sync_ff <= 2'h0;
      mosi_sync_ff <= 2'h0;
      cs_d_ff <= 1'h1;
      sck_d_ff <= 1'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
      sck_sync_ff <= {sck_sync_ff[0], link.sck};
      mosi_sync_ff <= {mosi_sync_ff[0], link.mosi};
      cs_d_ff <= cs_sync_ff[1];
      sck_d_ff <= sck_sync_ff[1];
    end
  end
  wire cs_low = !cs_sync_ff[1];
  wire cs_rise = cs_sync_ff[1] && !cs_d_ff;
  wire sck_rise = cs_low && sck_sync_ff[1] && !sck_d_ff;
  wire sck_fall = cs_low && !sck_sync_ff[1] && sck_d_ff;

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  logic [31:0] shift_ff;
  logic [6:0] bit_cnt_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= 32'h0;
      bit_cnt_ff <= 7'h0;
    end else if (!cs_low) begin
      bit_cnt_ff <= 7'h0;
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[30:0], mosi_sync_ff[1]};
      if (bit_cnt_ff != 7'h7f)
        bit_cnt_ff <= bit_cnt_ff + 7'h1;
    end
  end
  logic [7:0] opcode_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      opcode_ff <= 8'h0;
    else if (sck_rise && bit_cnt_ff == 7'(fesr_pkg::OP_BITS - 1))
      opcode_ff <= {shift_ff[6:0], mosi_sync_ff[1]};
  end

  // ----------------------------------------------------------------
  // Operation state
  // ----------------------------------------------------------------
  typedef enum {FESR_IDLE, FESR_BLOCK, FESR_CHIP, FESR_SUSLAT,
    FESR_SUSP, FESR_RESUMING} fesr_state_t;
  fesr_state_t state_ff;
  logic [fesr_pkg::CNT_W-1:0] timer_ff, left_ff;
  logic susp_chip_ff;
  logic post_lat_ff;
  wire [7:0] op = opcode_ff;
  wire len_op = bit_cnt_ff == 7'(fesr_pkg::OP_BITS);
  wire len_addr = bit_cnt_ff == 7'(fesr_pkg::ERASE_BITS);
  // Block index from A23-A16; low bits ignored
  wire [7:0] blk = shift_ff[fesr_pkg::BLOCK_LSB +: 8];
  // Protection map: nonzero bits cover upper blocks by count
  wire blk_prot = block_protect != fesr_pkg::BP_NONE &&
    blk >= 8'(8'h4 - {3'h0, block_protect[2:0]});
  wire do_block = cs_rise && op == fesr_pkg::OP_BLOCK64_ERASE &&
    state_ff == FESR_IDLE && len_addr && write_enable_latch_ff &&
    !blk_prot;
  wire is_chip = op == fesr_pkg::OP_CHIP_ERASE_A ||
    op == fesr_pkg::OP_CHIP_ERASE_B;
  wire do_chip = cs_rise && is_chip && len_op && write_enable_latch_ff &&
    state_ff == FESR_IDLE && block_protect == fesr_pkg::BP_NONE;
  wire running = state_ff == FESR_BLOCK || state_ff == FESR_CHIP;
  // Chip erase and non-array ops are not suspendable here
  wire do_susp = cs_rise && op == fesr_pkg::OP_SUSPEND && len_op &&
    running;
  wire do_resume = cs_rise && op == fesr_pkg::OP_RESUME && len_op &&
    suspend_status_flag_ff && !busy_flag_ff &&
    !power_lost;
  // Write enable during suspend only after latency, erase type
  wire do_wren = cs_rise && op == fesr_pkg::OP_WRITE_ENABLE && len_op &&
    (state_ff == FESR_IDLE || (state_ff == FESR_SUSP && post_lat_ff));
  wire do_wrdis = cs_rise && op == fesr_pkg::OP_WRITE_DISABLE && len_op &&
    !busy_flag_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= FESR_IDLE;
      timer_ff <= '0;
      left_ff <= '0;
      susp_chip_ff <= 1'h0;
      post_lat_ff <= 1'h0;
    end else begin
      case (state_ff)
        FESR_IDLE: begin
          post_lat_ff <= 1'h0;
          if (do_block) begin
            state_ff <= FESR_BLOCK;
            timer_ff <= CNT_W'(BLOCK_ERASE_CYC);
          end else if (do_chip) begin
            state_ff <= FESR_CHIP;
            timer_ff <= CNT_W'(CHIP_ERASE_CYC);
          end
        end
        FESR_BLOCK, FESR_CHIP: begin
          if (do_susp && state_ff == FESR_BLOCK) begin
            left_ff <= timer_ff;
            susp_chip_ff <= 1'h0;
            timer_ff <= CNT_W'(SUSPEND_LAT_CYC);
            state_ff <= FESR_SUSLAT;
          end else if (timer_ff <= CNT_W'(1))
            state_ff <= FESR_IDLE;
          else
            timer_ff <= timer_ff - CNT_W'(1);
        end
        FESR_SUSLAT: begin
          if (timer_ff <= CNT_W'(1)) begin
            state_ff <= FESR_SUSP;
            post_lat_ff <= 1'h1;
          end else
            timer_ff <= timer_ff - CNT_W'(1);
        end
        FESR_SUSP: begin
          if (do_resume) begin
            state_ff <= FESR_RESUMING;
            timer_ff <= CNT_W'(fesr_pkg::RESUME_BUSY_CYC);
          end
        end
        FESR_RESUMING: begin
          timer_ff <= left_ff;
          post_lat_ff <= 1'h0;
          state_ff <= susp_chip_ff ? FESR_CHIP : FESR_BLOCK;
        end
        default: state_ff <= FESR_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  wire erase_done = running && !do_susp && timer_ff <= CNT_W'(1);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag_ff <= 1'h0;
      write_enable_latch_ff <= 1'h0;
      suspend_status_flag_ff <= 1'h0;
    end else begin
      // Busy through erase and suspend latency; drops once suspended
      busy_flag_ff <= (state_ff == FESR_IDLE) ? (do_block || do_chip) :
        (state_ff == FESR_SUSP) ? do_resume :
        !(state_ff == FESR_SUSLAT && timer_ff <= CNT_W'(1)) &&
        !erase_done;
      if (erase_done || do_wrdis)
        write_enable_latch_ff <= 1'h0;
      else if (state_ff == FESR_SUSLAT && timer_ff <= CNT_W'(1))
        write_enable_latch_ff <= 1'h0;
      else if (do_block || do_chip)
        write_enable_latch_ff <= write_enable_latch_ff;
      else if (do_wren)
        write_enable_latch_ff <= 1'h1;
      if (state_ff == FESR_SUSLAT && timer_ff <= CNT_W'(1))
        suspend_status_flag_ff <= 1'h1;
      else if (do_resume)
        suspend_status_flag_ff <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Array erase strobes: erased block number latched for array control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_block_ff <= 1'h0;
      erase_block_num_ff <= 8'h0;
      erase_chip_ff <= 1'h0;
    end else begin
      // Pulse at completion: block set to all ones
      erase_block_ff <= erase_done && state_ff == FESR_BLOCK;
      erase_chip_ff <= erase_done && state_ff == FESR_CHIP;
      if (do_block)
        erase_block_num_ff <= blk;
    end
  end

  // ----------------------------------------------------------------
  // Status read: 05h low byte, 35h high byte, served always
  // ----------------------------------------------------------------
  logic [7:0] sout_ff;
  logic miso_ff;
  wire stat_op = op == fesr_pkg::OP_READ_STATUS1 ||
    op == fesr_pkg::OP_READ_STATUS2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_ff <= 8'h0;
      miso_ff <= 1'h0;
    end else if (sck_rise && bit_cnt_ff == 7'(fesr_pkg::OP_BITS - 1)) begin
      sout_ff <= 8'h0;
      if ({shift_ff[6:0], mosi_sync_ff[1]} == fesr_pkg::OP_READ_STATUS1) begin
        sout_ff[fesr_pkg::BUSY_BIT] <= busy_flag_ff;
        sout_ff[fesr_pkg::WEL_BIT] <= write_enable_latch_ff;
      end else if ({shift_ff[6:0], mosi_sync_ff[1]} ==
        fesr_pkg::OP_READ_STATUS2)
        sout_ff[fesr_pkg::SUS_BIT2] <= suspend_status_flag_ff;
    end else if (sck_fall && stat_op &&
      bit_cnt_ff >= 7'(fesr_pkg::OP_BITS)) begin
      miso_ff <= sout_ff[7];
      sout_ff <= {sout_ff[6:0], 1'h0};
    end else if (!cs_low)
      miso_ff <= 1'h0;
  end
  assign link.miso = miso_ff;
endmodule : fesr_device

/* logic/fesr_host.sv */
// Host side: turns register commands into serial frames for the flash.
// Assumes miso is asynchronous and sampled on sys_clk.
`timescale 1ns/1ns
module fesr_host #(
  parameter int SCK_HALF = 8,
  parameter int ERASE_GAP = fesr_pkg::ERASE_GAP_CYC,
  parameter int PROG_GAP = fesr_pkg::PROG_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  fesr_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_ff
);
  localparam int CNT_W = fesr_pkg::CNT_W;
  // ----------------------------------------------------------------
  // Registers: 0 command (wr: [2:0] code, [31:8] addr), 1 status
  // ----------------------------------------------------------------
  logic [1:0] miso_sync_ff;
  logic [31:0] tx_ff;
  logic [7:0] rx_ff;
  logic [6:0] bits_ff;
  logic [7:0] div_ff;
  logic sck_ff, cs_n_ff, mosi_ff, act_ff, rx_en_ff;
  logic [CNT_W-1:0] gap_ff;
  wire gap_busy = gap_ff != '0;
  wire start = wr && addr == 2'h0 && !act_ff;
  logic [31:0] frame;
  logic [6:0] nbits;
  logic stat;
  always_comb begin
    frame = {fesr_pkg::OP_WRITE_ENABLE, 24'h0};
    nbits = 7'h8;
    stat = 1'h0;
    case (wdata[2:0])
      fesr_pkg::HC_ERASE64: begin
        frame = {fesr_pkg::OP_BLOCK64_ERASE, wdata[31:8]};
        nbits = 7'(fesr_pkg::ERASE_BITS);
      end
      fesr_pkg::HC_CHIP: frame = {fesr_pkg::OP_CHIP_ERASE_A, 24'h0};
      fesr_pkg::HC_CHIP_B:
        frame = {fesr_pkg::OP_CHIP_ERASE_B, 24'h0};
      fesr_pkg::HC_SUSPEND: frame = {fesr_pkg::OP_SUSPEND, 24'h0};
      fesr_pkg::HC_RESUME: frame = {fesr_pkg::OP_RESUME, 24'h0};
      fesr_pkg::HC_STAT1: begin
        frame = {fesr_pkg::OP_READ_STATUS1, 24'h0};
        nbits = 7'h10;
        stat = 1'h1;
      end
      fesr_pkg::HC_STAT2: begin
        frame = {fesr_pkg::OP_READ_STATUS2, 24'h0};
        nbits = 7'h10;
        stat = 1'h1;
      end
      default: frame = {fesr_pkg::OP_WRITE_ENABLE, 24'h0};
    endcase
  end
  // Suspend refused and dropped, not deferred, while the gap after resume runs
  wire refuse = wdata[2:0] == fesr_pkg::HC_SUSPEND && gap_busy;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_sync_ff <= 2'h0;
      gap_ff <= '0;
    end else begin
      miso_sync_ff <= {miso_sync_ff[0], link.miso};
      if (start && wdata[2:0] == fesr_pkg::HC_RESUME)
        gap_ff <= CNT_W'(ERASE_GAP > PROG_GAP ? ERASE_GAP : PROG_GAP);
      else if (gap_busy)
        gap_ff <= gap_ff - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Frame engine: mode 0, cs raised one half sck period after last bit
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff <= 32'h0;
      rx_ff <= 8'h0;
      bits_ff <= 7'h0;
      div_ff <= 8'h0;
      sck_ff <= 1'h0;
      cs_n_ff <= 1'h1;
      mosi_ff <= 1'h0;
      act_ff <= 1'h0;
      rx_en_ff <= 1'h0;
    end else if (!act_ff) begin
      if (start && !refuse) begin
        act_ff <= 1'h1;
        cs_n_ff <= 1'h0;
        tx_ff <= {frame[30:0], 1'h0};
        mosi_ff <= frame[31];
        bits_ff <= nbits;
        rx_en_ff <= stat;
        div_ff <= 8'(SCK_HALF);
      end
    end else if (div_ff != 8'h0) begin
      div_ff <= div_ff - 8'h1;
    end else begin
      div_ff <= 8'(SCK_HALF);
      if (bits_ff == 7'h0) begin
        cs_n_ff <= 1'h1;
        act_ff <= 1'h0;
      end else if (!sck_ff) begin
        sck_ff <= 1'h1;
        if (rx_en_ff && bits_ff <= 7'h8)
          rx_ff <= {rx_ff[6:0], miso_sync_ff[1]};
      end else begin
        sck_ff <= 1'h0;
        bits_ff <= bits_ff - 7'h1;
        mosi_ff <= tx_ff[31];
        tx_ff <= {tx_ff[30:0], 1'h0};
      end
    end
  end
  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.mosi = mosi_ff;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rdata_ff <= 32'h0;
    else if (rd)
      rdata_ff <= addr == 2'h1 ? {22'h0, gap_busy, act_ff, rx_ff} : 32'h0;
  end
endmodule : fesr_host

/* sim/fesr_erase_props.sv */
// Checker for the flash erase link and device status flags.
// Assumes it is instantiated beside the link interface in the testbench.
`timescale 1ns/1ns
module fesr_erase_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic power_lost,
  input wire logic erase_block_ff,
  input wire logic [7:0] erase_block_num_ff,
  input wire logic erase_chip_ff,
  input wire logic busy_flag_ff,
  input wire logic write_enable_latch_ff,
  input wire logic suspend_status_flag_ff
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int RES_MAX = 50;
  logic cs_q_ff;
  logic [7:0] cs_age_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q_ff <= 1'b1;
      cs_age_ff <= 8'hff;
    end else begin
      cs_q_ff <= cs_n;
      if (cs_n && !cs_q_ff) cs_age_ff <= 8'h00;
      else if (cs_age_ff != 8'hff) cs_age_ff <= cs_age_ff + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_done_clr;
    erase_block_ff |-> ##[0:2] (!write_enable_latch_ff && !busy_flag_ff);
  endproperty
  property p_chip_clr;
    erase_chip_ff |-> ##[0:2] (!write_enable_latch_ff && !busy_flag_ff);
  endproperty
  property p_start_wel;
    $rose(busy_flag_ff) |-> write_enable_latch_ff ||
      $past(suspend_status_flag_ff) || $past(suspend_status_flag_ff, 2);
  endproperty
  property p_start_cs;
    $rose(busy_flag_ff) |-> cs_age_ff <= 8'h08;
  endproperty
  property p_busy_hold;
    $rose(busy_flag_ff) |-> busy_flag_ff [*8];
  endproperty
  property p_sus_set;
    $rose(suspend_status_flag_ff) |-> !write_enable_latch_ff && !busy_flag_ff;
  endproperty
  property p_sus_run;
    $rose(suspend_status_flag_ff) |-> $past(busy_flag_ff) ||
      $past(busy_flag_ff, 2);
  endproperty
  property p_res_ok;
    $fell(suspend_status_flag_ff) |-> !$past(busy_flag_ff) &&
      !$past(power_lost);
  endproperty
  property p_res_busy;
    $fell(suspend_status_flag_ff) |-> ##[0:RES_MAX] busy_flag_ff;
  endproperty
  property p_num_hold;
    busy_flag_ff && $past(busy_flag_ff) |-> $stable(erase_block_num_ff);
  endproperty
  property p_miso_idle;
    cs_n && $past(cs_n, 3) |-> !miso;
  endproperty
  property p_cs_rise;
    $rose(cs_n) |-> !sck;
  endproperty
  property p_mosi_hold;
    $rose(sck) |-> $stable(mosi);
  endproperty
  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  a_done_clr: assert property (p_done_clr) else $error("done");
  a_chip_clr: assert property (p_chip_clr) else $error("chip");
  a_start_wel: assert property (p_start_wel) else $error("no wel");
  a_start_cs: assert property (p_start_cs) else $error("late busy");
  a_busy_hold: assert property (p_busy_hold) else $error("short");
  a_sus_set: assert property (p_sus_set) else $error("sus flags");
  a_sus_run: assert property (p_sus_run) else $error("idle sus");
  a_res_ok: assert property (p_res_ok) else $error("bad resume");
  a_res_busy: assert property (p_res_busy) else $error("res busy");
  a_num_hold: assert property (p_num_hold) else $error("num moved");
  a_miso_idle: assert property (p_miso_idle) else $error("miso");
  a_cs_rise: assert property (p_cs_rise) else $error("cs edge");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi");
  c_block: cover property (erase_block_ff);
  c_chip: cover property (erase_chip_ff);
  c_sus: cover property ($rose(suspend_status_flag_ff));
  c_res: cover property ($fell(suspend_status_flag_ff));
endmodule : fesr_erase_props

/* sim/testbench.sv */
// Self-checking bench: host and device joined over the serial link.
// Assumes shortened erase counts and hold-off gaps for simulation.
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_ff;
  logic [4:0] block_protect = 5'h00;
  logic power_lost = 1'b0;
  logic erase_block_ff, erase_chip_ff, busy_flag_ff;
  logic write_enable_latch_ff, suspend_status_flag_ff;
  logic [7:0] erase_block_num_ff;
  logic [31:0] d;
  logic [7:0] s;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int blk_done = 0;
  int chip_done = 0;
  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  fesr_link_if link();
  fesr_host #(.ERASE_GAP(1000), .PROG_GAP(1000)) u_fesr_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff));
  fesr_device #(.BLOCK_ERASE_CYC(3000), .CHIP_ERASE_CYC(4000),
    .SUSPEND_LAT_CYC(10)) u_fesr_device (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .block_protect(block_protect), .power_lost(power_lost),
    .erase_block_ff(erase_block_ff),
    .erase_block_num_ff(erase_block_num_ff),
    .erase_chip_ff(erase_chip_ff), .busy_flag_ff(busy_flag_ff),
    .write_enable_latch_ff(write_enable_latch_ff),
    .suspend_status_flag_ff(suspend_status_flag_ff));
  fesr_erase_props u_fesr_erase_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .power_lost(power_lost),
    .erase_block_ff(erase_block_ff),
    .erase_block_num_ff(erase_block_num_ff),
    .erase_chip_ff(erase_chip_ff), .busy_flag_ff(busy_flag_ff),
    .write_enable_latch_ff(write_enable_latch_ff),
    .suspend_status_flag_ff(suspend_status_flag_ff));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (erase_block_ff === 1'b1) blk_done++;
    if (erase_chip_ff === 1'b1) chip_done++;
    cyc++;
    if (cyc == 80000) begin
      failures++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus_rd();
    @(posedge sys_clk);
    addr <= 2'h1;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata_ff;
  endtask : bus_rd
  task automatic send(input logic [2:0] code, input logic [23:0] a);
    int i;
    @(posedge sys_clk);
    addr <= 2'h0;
    wdata <= {a, 5'h00, code};
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    i = 0;
    d = 32'h100;
    while (d[8] !== 1'b0 && i < 3000) begin
      bus_rd();
      i++;
    end
    chk("frame_end", d[8], 1'b0);
    repeat (8) @(posedge sys_clk);
  endtask : send
  task automatic stat(input logic [2:0] code);
    send(code, 24'h000000);
    bus_rd();
    s = d[7:0];
  endtask : stat
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy_flag_ff !== 1'b0 && i < 6000) begin
      @(posedge sys_clk);
      i++;
    end
    repeat (3) @(posedge sys_clk);
  endtask : wait_idle
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("flags", {busy_flag_ff, write_enable_latch_ff,
      suspend_status_flag_ff}, 3'h0);
    chk("cs_n", link.cs_n, 1'b1);
    chk("rdata", rdata_ff, 32'h0);
    $display("reset test done");
    send(fesr_pkg::HC_WREN, 24'h000000);
    chk("wel", write_enable_latch_ff, 1'b1);
    send(fesr_pkg::HC_ERASE64, 24'h05abcd);
    stat(fesr_pkg::HC_STAT1);
    chk("busy_stat", s[1:0], 2'h3);
    send(fesr_pkg::HC_ERASE64, 24'h000000);
    wait_idle();
    chk("blk_done", blk_done, 1);
    chk("blk_num", erase_block_num_ff, 8'h05);
    chk("wel_end", write_enable_latch_ff, 1'b0);
    send(fesr_pkg::HC_ERASE64, 24'h020000);
    chk("no_wel", busy_flag_ff, 1'b0);
    $display("block erase test done");
    @(posedge sys_clk);
    block_protect <= 5'h01;
    send(fesr_pkg::HC_WREN, 24'h000000);
    send(fesr_pkg::HC_ERASE64, 24'h030000);
    chk("prot_blk", busy_flag_ff, 1'b0);
    send(fesr_pkg::HC_CHIP, 24'h000000);
    chk("prot_chip", busy_flag_ff, 1'b0);
    send(fesr_pkg::HC_ERASE64, 24'h02ffff);
    chk("free_blk", busy_flag_ff, 1'b1);
    wait_idle();
    chk("free_num", erase_block_num_ff, 8'h02);
    block_protect <= 5'h00;
    send(fesr_pkg::HC_WREN, 24'h000000);
    send(fesr_pkg::HC_CHIP, 24'h000000);
    chk("chip_busy", busy_flag_ff, 1'b1);
    wait_idle();
    chk("chip_done", chip_done, 1);
    chk("chip_wel", write_enable_latch_ff, 1'b0);
    send(fesr_pkg::HC_WREN, 24'h000000);
    send(fesr_pkg::HC_CHIP_B, 24'h000000);
    chk("chip_b_busy", busy_flag_ff, 1'b1);
    wait_idle();
    chk("chip_b_done", chip_done, 2);
    $display("protect and chip test done");
    send(fesr_pkg::HC_WREN, 24'h000000);
    send(fesr_pkg::HC_ERASE64, 24'h010000);
    send(fesr_pkg::HC_SUSPEND, 24'h000000);
    repeat (20) @(posedge sys_clk);
    chk("sus", {suspend_status_flag_ff, write_enable_latch_ff,
      busy_flag_ff}, 3'h4);
    stat(fesr_pkg::HC_STAT2);
    chk("sus_bit", s[7], 1'b1);
    @(posedge sys_clk);
    power_lost <= 1'b1;
    send(fesr_pkg::HC_RESUME, 24'h000000);
    chk("res_lost", suspend_status_flag_ff, 1'b1);
    power_lost <= 1'b0;
    send(fesr_pkg::HC_RESUME, 24'h000000);
    chk("res", {suspend_status_flag_ff, busy_flag_ff}, 2'h1);
    bus_rd();
    chk("holdoff", d[9], 1'b1);
    send(fesr_pkg::HC_SUSPEND, 24'h000000);
    repeat (20) @(posedge sys_clk);
    chk("sus_gap", suspend_status_flag_ff, 1'b0);
    wait_idle();
    chk("res_done", blk_done, 3);
    chk("res_num", erase_block_num_ff, 8'h01);
    send(fesr_pkg::HC_SUSPEND, 24'h000000);
    repeat (20) @(posedge sys_clk);
    chk("idle_sus", suspend_status_flag_ff, 1'b0);
    send(fesr_pkg::HC_RESUME, 24'h000000);
    chk("idle_res", busy_flag_ff, 1'b0);
    $display("suspend resume test done");
    wrap_up();
  end
endmodule : testbench
